// >>> hw/dcc_top.sv
// Module: dual comparator control and status registers with AXI4-Lite slave
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Functional notes
// R1: Two independent comparators, each with its own control; one shared status register.
// R2: Each comparator's inputs are chosen among five sources by its select fields.
// R3: Pad output enable passes the unsynchronised result to the pad; else internal.
// R4: Status and both control registers have clear, set and invert aliases at +4, +8, +C.
// R5: Status bit 17 mirrors comparator two's event flag, control bit 9.
// R6: Status bit 16 mirrors comparator one's event flag.
// R7: Status bit 1 mirrors comparator two's result, control bit 8.
// R8: Status bit 0 mirrors comparator one's result.
// R9: Stop-in-idle set halts all comparators while the device idles.
// R10: Status bit 8 picks reference: 1 external pin, 0 control DAC.
// R11: Unimplemented bits ignore writes and read as zero.
// R12: Status and both control registers reset to zero.
// R13: Event and result bits are hardware driven; software sets have no effect.
// R14: Event flag sets on trigger; further triggers blocked until software clears it.
// R15: Trigger polarity 11 any, 10 fall, 01 rise, 00 off; swapped by inversion.
// R16: Inversion bit inverts the result before reporting and event use.
// R17: Control bit 15 enables the comparator.
// R18: Alias writes of ones clear, set or toggle writable bits; others unchanged.
// R19: Raw results pass a two-stage synchroniser before status and edge use.
module dcc_top
  import dcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [DCC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DCC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DCC_N_CMP-1:0] cmpRaw,
  input wire logic idleMode,
  output logic [DCC_N_CMP-1:0] cmpRun,
  output logic [DCC_N_CMP-1:0] padOutputEnable,
  output logic [DCC_N_CMP-1:0] padInvert,
  output logic [DCC_N_CMP-1:0] nonInvertingReferenceSelect,
  output logic [2*DCC_N_CMP-1:0] invertingChannelSelect,
  output logic referenceSourceSelect,
  output logic irq
);
  // ******************************
  // State
  // ******************************
  logic [31:0] stat, next_stat;
  logic [31:0] ctl [DCC_N_CMP];
  logic [31:0] next_ctl [DCC_N_CMP];
  logic [DCC_N_CMP-1:0] event_flag, next_event_flag, runQ, next_runQ, intSt, next_intSt, intMsk, next_intMsk;
  logic [DCC_N_CMP-1:0] resultV, trigV;
  logic awHeld, next_awHeld, wHeld, next_wHeld, awRdy, next_awRdy, wRdy, next_wRdy;
  logic [DCC_AW-1:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic bValid, next_bValid, arRdy, next_arRdy, rValid, next_rValid, irqQ, next_irqQ;
  logic [1:0] bResp, next_bResp, rResp, next_rResp;
  logic [31:0] rData, next_rData;
  logic doWrite;
  dcc_sel_t wSel;
  logic [31:0] tmp, wBits;

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strobe_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // Plain write or clear/set/invert alias applied to writable bits only
  function automatic logic [31:0] alias_apply(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [31:0] wm,
                                              input logic [1:0] kind);
    logic [31:0] m;
    m = wm & strobe_mask(be);                  // [R11]
    case (kind)                                // [R18]
      DCC_AL_CLR: return old & ~(wd & m);
      DCC_AL_SET: return old | (wd & m);
      DCC_AL_INV: return old ^ (wd & m);
      default: return (old & ~m) | (wd & m);
    endcase
  endfunction

  // Address to register; aliases fold onto their base
  function automatic dcc_sel_t decode(input logic [DCC_AW-1:0] a);
    if (a == DCC_OFF_INTST) begin
      return DCC_SEL_INTST;
    end else if (a == DCC_OFF_INTMSK) begin
      return DCC_SEL_INTMSK;
    end else if ((a & ~DCC_ALIAS_MASK) == DCC_OFF_STAT) begin // [R4]
      return DCC_SEL_STAT;
    end else if ((a & ~DCC_ALIAS_MASK) == DCC_OFF_CTL1) begin
      return DCC_SEL_CTL1;
    end else if ((a & ~DCC_ALIAS_MASK) == DCC_OFF_CTL2) begin
      return DCC_SEL_CTL2;
    end else begin
      return DCC_SEL_NONE;
    end
  endfunction

  // Live views: hardware bits merged over stored writable bits
  function automatic logic [31:0] ctl_view(input logic [31:0] c, input logic e, input logic r);
    logic [31:0] v;
    v = c & DCC_CTL_WMASK;
    v[DCC_B_EVT] = e;
    v[DCC_B_OUT] = r;
    return v;
  endfunction

  logic [31:0] statView;
  always_comb begin
    statView = stat & DCC_STAT_WMASK;
    statView[DCC_B_EVTM +: DCC_N_CMP] = event_flag;   // [R5] [R6]
    statView[DCC_B_OUTM +: DCC_N_CMP] = resultV; // [R7] [R8]
  end

  // ******************************
  // Comparator channels
  // ******************************
  dcc_chan_if chIf [DCC_N_CMP] ();
  generate
    for (genvar g = 0; g < DCC_N_CMP; g++) begin : gen_ch // [R1]
      assign chIf[g].rawIn = cmpRaw[g];
      assign chIf[g].enable = ctl[g][DCC_B_ON];  // [R17]
      assign chIf[g].run = runQ[g];
      assign chIf[g].invert = ctl[g][DCC_B_POL];
      assign chIf[g].trigPol = ctl[g][DCC_B_TRIG +: 2];
      assign chIf[g].flag = event_flag[g];
      assign resultV[g] = chIf[g].result;
      assign trigV[g] = chIf[g].trig;
      dcc_channel u_ch (.mclk(mclk), .rst(rst), .ch(chIf[g]));
      // Configuration outputs; the pad path itself is analog and unclocked
      assign padOutputEnable[g] = ctl[g][DCC_B_OE];   // [R3]
      assign padInvert[g] = ctl[g][DCC_B_POL];
      assign nonInvertingReferenceSelect[g] = ctl[g][DCC_B_NREF]; // [R2]
      assign invertingChannelSelect[2*g +: 2] = ctl[g][DCC_B_ICH +: 2];
    end
  endgenerate
  assign cmpRun = runQ;
  assign referenceSourceSelect = stat[DCC_B_REFSEL]; // [R10]
  assign irq = irqQ;

  // ******************************
  // Register file
  // ******************************
  assign doWrite = awHeld && wHeld && !bValid;
  assign wSel = decode(awAddr);
  assign wBits = strobe_mask(wStrb);
  always_comb begin
    next_stat = stat;
    next_ctl = ctl;
    next_intMsk = intMsk;
    tmp = 32'h00000000;
    next_event_flag = event_flag;
    next_intSt = intSt | trigV;
    if (doWrite) begin
      if (wSel == DCC_SEL_STAT) begin
        // Mirrors are not stored, so software cannot touch them
        next_stat = alias_apply(stat, wData, wStrb, DCC_STAT_WMASK, awAddr[3:2]); // [R13]
      end else if (wSel == DCC_SEL_CTL1 || wSel == DCC_SEL_CTL2) begin
        for (int i = 0; i < DCC_N_CMP; i++) begin
          if (wSel == ((i == 0) ? DCC_SEL_CTL1 : DCC_SEL_CTL2)) begin
            tmp = alias_apply(ctl_view(ctl[i], event_flag[i], resultV[i]), wData, wStrb,
                              DCC_CTL_WMASK | (32'h00000001 << DCC_B_EVT), awAddr[3:2]);
            next_ctl[i] = tmp & DCC_CTL_WMASK;
            // Software may only clear the flag
            next_event_flag[i] = event_flag[i] & tmp[DCC_B_EVT]; // [R14] [R13]
          end
        end
      end else if (wSel == DCC_SEL_INTST) begin
        next_intSt = (intSt & ~(wData[DCC_N_CMP-1:0] & wBits[DCC_N_CMP-1:0])) | trigV;
      end else if (wSel == DCC_SEL_INTMSK) begin
        next_intMsk = (wData[DCC_N_CMP-1:0] & wBits[DCC_N_CMP-1:0]) | (intMsk & ~wBits[DCC_N_CMP-1:0]);
      end
    end
    // A trigger in the clearing cycle still sets the flag
    next_event_flag = next_event_flag | trigV;              // [R14]
    for (int i = 0; i < DCC_N_CMP; i++) begin
      next_runQ[i] = ctl[i][DCC_B_ON] && !(stat[DCC_B_IDLE] && idleMode); // [R9] [R17]
    end
    next_irqQ = |(intSt & intMsk);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stat <= DCC_RESET_VAL;                   // [R12]
      ctl <= '{default: DCC_RESET_VAL};
      event_flag <= '0;
      runQ <= '0;
      intSt <= '0;
      intMsk <= '0;
      irqQ <= 1'b0;
    end else begin
      stat <= next_stat;
      ctl <= next_ctl;
      event_flag <= next_event_flag;
      runQ <= next_runQ;
      intSt <= next_intSt;
      intMsk <= next_intMsk;
      irqQ <= next_irqQ;
    end
  end

  // ******************************
  // AXI4-Lite handshake
  // ******************************
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    next_arRdy = arRdy || !rValid; // Re-armed whenever no read data is pending
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    if (s_axi_bready && bValid) begin
      next_bValid = 1'b0;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = (wSel == DCC_SEL_NONE) ? DCC_RESP_SLVERR : DCC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awRdy) begin
        next_awHeld = 1'b1;
        next_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && wRdy) begin
        next_wHeld = 1'b1;
        next_wData = s_axi_wdata;
        next_wStrb = s_axi_wstrb;
      end
    end
    // Ready drops while a word is held, so nothing is taken twice
    next_awRdy = !next_awHeld;
    next_wRdy = !next_wHeld;
    if (s_axi_rready && rValid) begin
      next_rValid = 1'b0;
      next_arRdy = 1'b1;
    end
    if (s_axi_arvalid && arRdy) begin
      next_arRdy = 1'b0;
      next_rValid = 1'b1;
      next_rResp = DCC_RESP_OKAY;
      // Alias reads return the base value
      case (decode(s_axi_araddr))
        DCC_SEL_STAT: next_rData = statView;
        DCC_SEL_CTL1: next_rData = ctl_view(ctl[0], event_flag[0], resultV[0]);
        DCC_SEL_CTL2: next_rData = ctl_view(ctl[1], event_flag[1], resultV[1]);
        DCC_SEL_INTST: next_rData = {{(32-DCC_N_CMP){1'b0}}, intSt};
        DCC_SEL_INTMSK: next_rData = {{(32-DCC_N_CMP){1'b0}}, intMsk};
        default: begin
          next_rData = 32'h00000000;
          next_rResp = DCC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= '0;
      wHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      awRdy <= 1'b0;
      wRdy <= 1'b0;
      bValid <= 1'b0;
      bResp <= DCC_RESP_OKAY;
      arRdy <= 1'b0;
      rValid <= 1'b0;
      rData <= 32'h00000000;
      rResp <= DCC_RESP_OKAY;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      awRdy <= next_awRdy;
      wRdy <= next_wRdy;
      bValid <= next_bValid;
      bResp <= next_bResp;
      arRdy <= next_arRdy;
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end
  assign s_axi_awready = awRdy;
  assign s_axi_wready = wRdy;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = arRdy;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;

  // ******************************
  // Checks
  // ******************************
  sequence s_set_on1;
    doWrite && wSel == DCC_SEL_CTL1 && awAddr[3:2] == DCC_AL_SET && wData[DCC_B_ON] && wStrb[1];
  endsequence
  a_alias_set: assert property (@(posedge mclk) disable iff (rst) // [R18]
    s_set_on1 |=> ctl[0][DCC_B_ON] ##1 cmpRun[0] || (stat[DCC_B_IDLE] && idleMode)) else $error("set alias failed");
  a_event_flag: assert property (@(posedge mclk) disable iff (rst) // [R14]
    trigV[1] |=> event_flag[1] && intSt[1]) else $error("event flag not set");
  a_mirror_read: assert property (@(posedge mclk) disable iff (rst) // [R5]
    (s_axi_arvalid && arRdy && s_axi_araddr == DCC_OFF_STAT) |=> rValid && rData[17:16] == $past(event_flag))
    else $error("event mirror wrong");
  a_result_mirror: assert property (@(posedge mclk) disable iff (rst) // [R8]
    statView[1:0] == resultV && statView[12:9] == 4'h0) else $error("result mirror wrong");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (s_axi_arvalid && arRdy) |=> (rData & ~(($past(decode(s_axi_araddr)) == DCC_SEL_STAT) ?
      (DCC_STAT_WMASK | 32'h00030003) : (DCC_CTL_WMASK | 32'h00000300))) == 32'h00000000)
    else $error("reserved bits nonzero");
  a_idle_stop: assert property (@(posedge mclk) disable iff (rst) // [R9]
    (stat[DCC_B_IDLE] && idleMode) |=> !cmpRun[0] && !cmpRun[1]) else $error("run during idle stop");
  a_irq_level: assert property (@(posedge mclk) disable iff (rst) // [R14]
    irq == $past(|(intSt & intMsk))) else $error("interrupt level wrong");
  a_reset_zero: assert property (@(posedge mclk) // [R12]
    $past(rst) |-> stat == 32'h00000000 && ctl[0] == 32'h00000000 && ctl[1] == 32'h00000000 && event_flag == '0)
    else $error("reset value wrong");
endmodule

// >>> common/dcc_pkg.sv
// Package: register map, field positions and codes for the dual comparator control block
package dcc_pkg;
  localparam int DCC_N_CMP = 2;
  localparam int DCC_AW = 8;
  // Register byte addresses (status and control bases have clear/set/invert aliases at +4/+8/+C)
  localparam logic [7:0] DCC_OFF_STAT = 8'h00;
  localparam logic [7:0] DCC_OFF_CTL1 = 8'h10;
  localparam logic [7:0] DCC_OFF_CTL2 = 8'h20;
  localparam logic [7:0] DCC_OFF_INTST = 8'h30;
  localparam logic [7:0] DCC_OFF_INTMSK = 8'h34;
  localparam logic [7:0] DCC_ALIAS_MASK = 8'h0C;
  // Alias kinds, taken from address bits 3:2
  localparam logic [1:0] DCC_AL_WR = 2'h0;
  localparam logic [1:0] DCC_AL_CLR = 2'h1;
  localparam logic [1:0] DCC_AL_SET = 2'h2;
  localparam logic [1:0] DCC_AL_INV = 2'h3;
  // Per-comparator control fields
  localparam int DCC_B_ON = 15;
  localparam int DCC_B_OE = 14;
  localparam int DCC_B_POL = 13;
  localparam int DCC_B_EVT = 9;
  localparam int DCC_B_OUT = 8;
  localparam int DCC_B_TRIG = 6;
  localparam int DCC_B_NREF = 4;
  localparam int DCC_B_ICH = 0;
  localparam logic [31:0] DCC_CTL_WMASK = 32'h0000E0D3;
  // Module status fields
  localparam int DCC_B_IDLE = 13;
  localparam int DCC_B_REFSEL = 8;
  localparam int DCC_B_EVTM = 16;
  localparam int DCC_B_OUTM = 0;
  localparam logic [31:0] DCC_STAT_WMASK = 32'h00002100;
  localparam logic [31:0] DCC_RESET_VAL = 32'h00000000;
  // Trigger polarity codes
  localparam logic [1:0] DCC_EV_OFF = 2'h0;
  localparam logic [1:0] DCC_EV_RISE = 2'h1;
  localparam logic [1:0] DCC_EV_FALL = 2'h2;
  localparam logic [1:0] DCC_EV_ANY = 2'h3;
  localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {DCC_SEL_STAT, DCC_SEL_CTL1, DCC_SEL_CTL2, DCC_SEL_INTST, DCC_SEL_INTMSK,
                            DCC_SEL_NONE} dcc_sel_t;
endpackage

// >>> common/dcc_chan_if.sv
// Interface: one comparator channel between the register file and its event logic
`timescale 1ns/100ps
interface dcc_chan_if;
  logic rawIn;
  logic enable;
  logic run;
  logic invert;
  logic [1:0] trigPol;
  logic flag;
  logic result;
  logic trig;
  modport chan (input rawIn, enable, run, invert, trigPol, flag, output result, trig);
  modport ctrl (output rawIn, enable, run, invert, trigPol, flag, input result, trig);
endinterface

// >>> hw/dcc_channel.sv
// Module: one comparator's synchroniser, polarity and trigger detection
`timescale 1ns/100ps
module dcc_channel
  import dcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  dcc_chan_if.chan ch
);
  logic s1, s2, prev, result, trig;
  logic next_s1, next_s2, next_prev, next_result, next_trig;
  logic cur, old;

  // Two-stage sync; only s2 and later flops feed the edge logic
  always_comb begin
    next_s1 = ch.rawIn;
    next_s2 = s1;                              // [R19]
    next_prev = s2;
    cur = s2 ^ ch.invert;                      // [R16]
    old = prev ^ ch.invert;
    // Disabled reads 0; idle stop freezes the last value
    next_result = ch.enable ? (ch.run ? cur : result) : 1'b0;
    next_trig = 1'b0;
    // Flag already set blocks further triggers
    if (ch.run && !ch.flag) begin               // [R14]
      case (ch.trigPol)                        // [R15]
        DCC_EV_ANY: next_trig = cur ^ old;
        DCC_EV_FALL: next_trig = old && !cur;
        DCC_EV_RISE: next_trig = cur && !old;
        default: next_trig = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      prev <= 1'b0;
      result <= 1'b0;
      trig <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      prev <= next_prev;
      result <= next_result;
      trig <= next_trig;
    end
  end

  assign ch.result = result;
  assign ch.trig = trig;

  // ******************************
  // Checks
  // ******************************
  a_sync_depth: assert property (@(posedge mclk) disable iff (rst) // [R19]
    !$past(rst, 2) |-> s2 == $past(ch.rawIn, 2)) else $error("sync depth wrong");
  a_polarity_apply: assert property (@(posedge mclk) disable iff (rst) // [R16]
    (ch.enable && ch.run && $stable(ch.invert)) |=> result == (s2 ^ ch.invert) || $changed(s2))
    else $error("polarity not applied");
  a_any_change: assert property (@(posedge mclk) disable iff (rst) // [R15]
    (ch.run && !ch.flag && ch.trigPol == DCC_EV_ANY && s2 != prev) |=> trig) else $error("change missed");
  a_trig_off: assert property (@(posedge mclk) disable iff (rst) // [R15]
    (ch.trigPol == DCC_EV_OFF || !ch.run) |=> !trig) else $error("trigger while disabled");
  a_flag_block: assert property (@(posedge mclk) disable iff (rst) // [R14]
    ch.flag |=> !trig) else $error("trigger while flag set");
endmodule

// >>> testbench/dcc_cmp_model.sv
// Partner model: the two analog comparator cores seen from the digital block
`timescale 1ns/100ps
module dcc_cmp_model (
  input wire logic [1:0] level,
  output logic [1:0] cmpRaw
);
  // ****************************************************
  // Analog output
  // ****************************************************
  // Outputs move off the clock edge, as a real comparator would, so the synchroniser is exercised
  initial begin
    cmpRaw = 2'h0;
  end
  always @(level) begin
    cmpRaw <= #3 level; // Unsynchronised result, one bit per comparator
  end
endmodule

// >>> testbench/dcc_top_test.sv
// Testbench: register bus tests of the dual comparator control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module dcc_top_test;
  import dcc_pkg::*;
  logic mclk, rst, idleMode;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, referenceSourceSelect;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, invertingChannelSelect;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br, cmpRaw, level, cmpRun, padOutputEnable;
  logic [1:0] padInvert, nonInvertingReferenceSelect;
  int errTotal, cmpCount, cycles;
  dcc_top dcc_top_inst (.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cmpRaw(cmpRaw),
    .idleMode(idleMode), .cmpRun(cmpRun), .padOutputEnable(padOutputEnable), .padInvert(padInvert),
    .nonInvertingReferenceSelect(nonInvertingReferenceSelect), .invertingChannelSelect(invertingChannelSelect),
    .referenceSourceSelect(referenceSourceSelect), .irq(irq));
  dcc_cmp_model dcc_cmp_model_inst (.level(level), .cmpRaw(cmpRaw));
  // ****************************************************
  // Clock, timeout and verdict
  // ****************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic endSim();
    if (errTotal == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      endSim();
    end
  end
  // ****************************************************
  // Bus tasks
  // ****************************************************
  // Both channels offered together; each is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        done = 1;
        br = s_axi_bresp;
      end
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    bit done;
    done = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        done = 1;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
  endtask
  // The result path is three edges and the flag one more; eight leaves margin for the model delay
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    errTotal = 0;
    cmpCount = 0;
    cycles = 0;
    rst = 1'b1;
    idleMode = 1'b0;
    level = 2'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    settle(2);
    rdr(8'h00); `CHK("status reset", 32'h00000000, rd)
    rdr(8'h10); `CHK("ctl one reset", 32'h00000000, rd)
    rdr(8'h20); `CHK("ctl two reset", 32'h00000000, rd)
    // Comparator one stays off so its result and flag bits must read zero
    wr(8'h10, 32'hFFFF60D3);
    `CHK("write resp", DCC_RESP_OKAY, br)
    rdr(8'h10); `CHK("ctl one fields", 32'h000060D3, rd)
    `CHK("pad enable", 1'b1, padOutputEnable[0])
    `CHK("pad invert", 1'b1, padInvert[0])
    `CHK("ref select one", 1'b1, nonInvertingReferenceSelect[0])
    `CHK("channel one", 2'h3, invertingChannelSelect[1:0])
    `CHK("run off", 1'b0, cmpRun[0])
    wr(8'h14, 32'h00004000);
    rdr(8'h10); `CHK("clear alias", 32'h000020D3, rd)
    wr(8'h18, 32'h00000300);
    rdr(8'h10); `CHK("set alias hw bits", 32'h000020D3, rd)
    wr(8'h1C, 32'h000000C3);
    rdr(8'h10); `CHK("invert alias", 32'h00002010, rd)
    rdr(8'h40); `CHK("unmapped resp", DCC_RESP_SLVERR, rr)
    `CHK("unmapped data", 32'h00000000, rd)
    wr(8'h40, 32'hFFFFFFFF);
    `CHK("unmapped wresp", DCC_RESP_SLVERR, br)
    wr(8'h00, 32'hFFFFFFFF);
    rdr(8'h00); `CHK("status writable", 32'h00002100, rd)
    `CHK("ref source pin", 1'b1, referenceSourceSelect)
    wr(8'h04, 32'h00000100);
    `CHK("ref source dac", 1'b0, referenceSourceSelect)
    // Comparator two: enabled, rising edge trigger, no inversion
    wr(8'h20, 32'h00008040);
    settle(8);
    rdr(8'h20); `CHK("two idle low", 32'h00008040, rd)
    level[1] <= 1'b1;
    settle(8);
    rdr(8'h20); `CHK("two rise event", 32'h00008340, rd)
    rdr(8'h00); `CHK("two mirrors", 32'h00020002, rd & 32'h00030003)
    `CHK("irq masked", 1'b0, irq)
    wr(8'h34, 32'hFFFFFFFF);
    settle(2);
    `CHK("irq raised", 1'b1, irq)
    wr(8'h30, 32'hFFFFFFFF);
    settle(2);
    `CHK("irq cleared", 1'b0, irq)
    // Flag still set: a new rising edge must not raise another event
    level[1] <= 1'b0;
    settle(8);
    level[1] <= 1'b1;
    settle(8);
    `CHK("irq blocked", 1'b0, irq)
    wr(8'h24, 32'h00000200);
    rdr(8'h20); `CHK("flag cleared", 32'h00008140, rd)
    rdr(8'h00); `CHK("two event mirror", 32'h00000002, rd & 32'h00030003)
    level[1] <= 1'b0;
    settle(8);
    rdr(8'h20); `CHK("fall ignored", 32'h00008040, rd)
    // Stop in idle is set: comparators halt and hold their result
    idleMode <= 1'b1;
    settle(2);
    `CHK("idle stop", 2'h0, cmpRun)
    level[1] <= 1'b1;
    settle(8);
    rdr(8'h20); `CHK("idle frozen", 32'h00008040, rd)
    level[1] <= 1'b0;
    idleMode <= 1'b0;
    settle(8);
    `CHK("idle resume", 2'h2, cmpRun)
    // Comparator one: inverted, falling edge of the reported result
    wr(8'h18, 32'h00008080);
    settle(8);
    rdr(8'h00); `CHK("one inverted", 32'h00000001, rd & 32'h00030003)
    level[0] <= 1'b1;
    settle(8);
    rdr(8'h00); `CHK("one fall event", 32'h00010000, rd & 32'h00030003)
    `CHK("irq one", 1'b1, irq)
    // Comparator two switched to any-change triggering
    wr(8'h28, 32'h00000080);
    level[1] <= 1'b1;
    settle(8);
    rdr(8'h20); `CHK("two any event", 32'h000083C0, rd)
    endSim();
  end
endmodule
